// File: core/xmb_top.sv
// External memory expansion bus controller with ports 4 to 6
`timescale 1ns/1ps
module xmb_top
  import xmb_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic hs_clk_sel_i,
  input wire logic cpu_req_i,
  input wire logic cpu_we_i,
  input wire logic [15:0] cpu_addr_i,
  input wire logic [7:0] cpu_wdata_i,
  output logic cpu_ack_o,
  output logic [7:0] cpu_rdata_o,
  input wire logic [7:0] pm4_i,
  input wire logic [7:0] pm5_i,
  input wire logic [7:0] pm6_i,
  input wire logic [7:0] port4_pins_i,
  output logic [7:0] port4_pins_o,
  output logic [7:0] port4_pins_oe_o,
  input wire logic [7:0] port5_pins_i,
  output logic [7:0] port5_pins_o,
  output logic [7:0] port5_pins_oe_o,
  input wire logic [7:0] port6_pins_i,
  output logic [7:0] port6_pins_o,
  output logic [7:0] port6_pins_oe_o
);

  xmb_state_e state_q; // Bus cycle state
  xmb_state_e state_d; // Next state
  xmb_req_s req_q; // Access being served
  logic ext_q; // Access goes to the external bus
  logic [2:0] mode_q; // Expansion mode field
  logic [1:0] wait_q; // Wait control field
  logic [2:0] mode_act_q; // Mode in force on the pins
  logic [1:0] wait_act_q; // Wait setting in force
  logic ack_q; // Access done pulse
  logic [7:0] rdata_q; // Read data
  logic exp_act; // Pins are in expansion use
  logic wait_in_act; // External wait pin asserted
  logic do_wr; // Write commit cycle
  logic [7:0] rd4; // Port 4 read value
  logic [7:0] rd5; // Port 5 read value
  logic [7:0] rd6; // Port 6 read value
  xmb_alt_s alt4; // Port 4 bus override
  xmb_alt_s alt5; // Port 5 bus override
  xmb_alt_s alt6; // Port 6 bus override

  assign exp_act = mode_is_exp(mode_act_q);
  assign wait_in_act = !port6_pins_i[P6_WAIT];
  assign do_wr = (state_q == S_HOLD) && req_q.we;

  // Bus cycle sequencer
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      S_IDLE: begin
        if (cpu_req_i) begin
          state_d = S_ADDR;
        end
      end
      S_ADDR: begin
        // Internal accesses never strobe read or write and ignore wait
        state_d = ext_q ? S_STRB : S_HOLD;
      end
      S_STRB: begin
        if (wait_act_q == WAIT_ONE) begin
          state_d = S_WAIT;
        end else if (wait_act_q == WAIT_EXT && wait_in_act) begin
          state_d = S_WAIT;
        end else begin
          state_d = S_HOLD;
        end
      end
      S_WAIT: begin
        // Stretch while the wait pin holds the cycle
        if (wait_act_q == WAIT_EXT && wait_in_act) begin
          state_d = S_WAIT;
        end else begin
          state_d = S_HOLD;
        end
      end
      S_HOLD: begin
        state_d = S_IDLE;
      end
      default: begin
        state_d = S_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= S_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Capture the access and decide where it goes
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      req_q <= '0;
      ext_q <= 1'b0;
    end else if (state_q == S_IDLE && cpu_req_i) begin
      req_q.we <= cpu_we_i;
      req_q.addr <= cpu_addr_i;
      req_q.wdata <= cpu_wdata_i;
      // External only in an expansion mode on the high-speed clock
      ext_q <= hs_clk_sel_i && mode_is_exp(mode_q) && addr_is_ext(cpu_addr_i);
    end
  end

  // Mode register; prohibited codes are not stored
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_q <= MODE_RESET[MODE_LSB +: 3];
    end else if (do_wr && req_q.addr == ADDR_MODE) begin
      if (mode_is_exp(req_q.wdata[MODE_LSB +: 3]) || req_q.wdata[MODE_LSB +: 3] == MODE_SINGLE) begin
        mode_q <= req_q.wdata[MODE_LSB +: 3];
      end
    end
  end

  // Wait register; the forbidden code is not stored
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wait_q <= WAIT_RESET[WAIT_LSB +: 2];
    end else if (do_wr && req_q.addr == ADDR_WAIT) begin
      if (req_q.wdata[WAIT_LSB +: 2] != WAIT_BAD) begin
        wait_q <= req_q.wdata[WAIT_LSB +: 2];
      end
    end
  end

  // Settings reach the pins only between accesses
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_act_q <= MODE_RESET[MODE_LSB +: 3];
      wait_act_q <= WAIT_RESET[WAIT_LSB +: 2];
    end else if (state_q == S_IDLE) begin
      mode_act_q <= mode_q;
      wait_act_q <= wait_q;
    end
  end

  // Port 4: multiplexed low address and data lines
  always_comb begin
    alt4.sel = exp_act ? 8'hff : 8'h00;
    alt4.val = req_q.addr[7:0];
    alt4.oe = 8'hff;
    if (state_q == S_STRB || state_q == S_WAIT || state_q == S_HOLD) begin
      if (ext_q && req_q.we) begin
        alt4.val = req_q.wdata;
      end else if (ext_q) begin
        alt4.oe = 8'h00;
      end
    end
  end

  // Port 5: upper address lines sized by the mode
  always_comb begin
    alt5.sel = mode_addr_mask(mode_act_q);
    alt5.val = req_q.addr[15:8];
    alt5.oe = 8'hff;
  end

  // Port 6: strobes on the upper pins, lower pins stay ports
  always_comb begin
    alt6.sel = 8'h00;
    alt6.val = 8'h00;
    alt6.oe = 8'h00;
    if (exp_act) begin
      alt6.sel[P6_RD] = 1'b1;
      alt6.sel[P6_WR] = 1'b1;
      alt6.sel[P6_ADDRESS_LATCH_STROBE] = 1'b1;
      alt6.sel[P6_WAIT] = (wait_act_q == WAIT_EXT);
      alt6.oe[P6_RD] = 1'b1;
      alt6.oe[P6_WR] = 1'b1;
      alt6.oe[P6_ADDRESS_LATCH_STROBE] = 1'b1;
      alt6.val[P6_ADDRESS_LATCH_STROBE] = (state_q == S_ADDR);
      alt6.val[P6_RD] = !((state_q == S_STRB || state_q == S_WAIT) && ext_q && !req_q.we);
      alt6.val[P6_WR] = !((state_q == S_STRB || state_q == S_WAIT) && ext_q && req_q.we);
    end
  end

  // Port blocks
  xmb_port u_port4 (
    .mclk_i (mclk_i),
    .rst_n_i (rst_n_i),
    .wr_i (do_wr && !ext_q && req_q.addr == ADDR_PORT4),
    .wdata_i (req_q.wdata),
    .pm_i (pm4_i),
    .pin_i (port4_pins_i),
    .alt_i (alt4),
    .rdata_o (rd4),
    .pin_o (port4_pins_o),
    .oe_o (port4_pins_oe_o)
  );

  xmb_port u_port5 (
    .mclk_i (mclk_i),
    .rst_n_i (rst_n_i),
    .wr_i (do_wr && !ext_q && req_q.addr == ADDR_PORT5),
    .wdata_i (req_q.wdata),
    .pm_i (pm5_i),
    .pin_i (port5_pins_i),
    .alt_i (alt5),
    .rdata_o (rd5),
    .pin_o (port5_pins_o),
    .oe_o (port5_pins_oe_o)
  );

  xmb_port u_port6 (
    .mclk_i (mclk_i),
    .rst_n_i (rst_n_i),
    .wr_i (do_wr && !ext_q && req_q.addr == ADDR_PORT6),
    .wdata_i (req_q.wdata),
    .pm_i (pm6_i),
    .pin_i (port6_pins_i),
    .alt_i (alt6),
    .rdata_o (rd6),
    .pin_o (port6_pins_o),
    .oe_o (port6_pins_oe_o)
  );

  // Completion pulse and read data
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_q <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      ack_q <= (state_q == S_HOLD);
      if (state_q == S_HOLD && !req_q.we) begin
        if (ext_q) begin
          rdata_q <= port4_pins_i;
        end else begin
          unique case (req_q.addr)
            ADDR_PORT4: rdata_q <= rd4;
            ADDR_PORT5: rdata_q <= rd5;
            ADDR_PORT6: rdata_q <= rd6;
            ADDR_MODE: rdata_q <= {5'h00, mode_q};
            ADDR_WAIT: rdata_q <= {2'h0, wait_q, 4'h0};
            default: rdata_q <= 8'h00;
          endcase
        end
      end
    end
  end

  assign cpu_ack_o = ack_q;
  assign cpu_rdata_o = rdata_q;

  // Assertions and covers share the bus clock and reset
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);

  // Only legal mode codes are ever held
  chk_mode_legal: assert property (
    mode_is_exp(mode_q) || mode_q == MODE_SINGLE)
    else $error("illegal mode held");

  // The forbidden wait code is never held
  chk_wait_legal: assert property (
    wait_q != WAIT_BAD)
    else $error("bad wait held");

  // No external cycle unless the CPU runs on the high-speed clock
  chk_clk_gate: assert property (
    (state_q == S_IDLE && cpu_req_i && !hs_clk_sel_i) |=> !ext_q)
    else $error("external access on slow clock");

  // Internal accesses finish in fixed time whatever the wait pin does
  chk_int_latency: assert property (
    (state_q == S_IDLE && cpu_req_i && !addr_is_ext(cpu_addr_i)) |-> ##3 cpu_ack_o)
    else $error("internal access latency");

  // Read strobe stays high through an internal access
  chk_rd_quiet: assert property (
    (state_q == S_ADDR && !ext_q && exp_act) |=> port6_pins_o[P6_RD] [*2])
    else $error("read strobe on internal access");

  // Write strobe stays high through an internal access
  chk_wr_quiet: assert property (
    (state_q == S_ADDR && !ext_q && exp_act) |=> port6_pins_o[P6_WR] [*2])
    else $error("write strobe on internal access");

  // External read drops the read strobe and frees the data lines
  chk_rd_pulse: assert property (
    (state_q == S_STRB && ext_q && !req_q.we) |=> !port6_pins_o[P6_RD] && !port4_pins_oe_o[0])
    else $error("missing read strobe");

  // Mode-assigned upper address bits match the access
  chk_hi_addr: assert property (
    (state_q == S_STRB && ext_q) |-> ((port5_pins_o & mode_addr_mask(mode_act_q))
      == (req_q.addr[15:8] & mode_addr_mask(mode_act_q))))
    else $error("upper address wrong");

  // Wait pin follows its port direction unless external wait is chosen
  chk_wait_port: assert property (
    (wait_act_q != WAIT_EXT) |=> port6_pins_oe_o[P6_WAIT] == !$past(pm6_i[P6_WAIT]))
    else $error("wait pin not a port");

  // Settings in force never change inside an access
  chk_mode_hold: assert property (
    (state_q != S_IDLE) |=> $stable(mode_act_q) && $stable(wait_act_q))
    else $error("setting changed mid access");

  // External access without waits completes in fixed time
  chk_ext_done: assert property (
    (state_q == S_ADDR && ext_q && wait_act_q == WAIT_NONE) |-> ##3 cpu_ack_o)
    else $error("external access latency");

  // Port 4 drives the bus lines in any expansion mode while ext_q is low
  chk_p4_owned: assert property (
    (exp_act && !ext_q) |=> port4_pins_oe_o == 8'hff)
    else $error("port 4 not driving bus");

  // Lower port 6 pins stay ordinary ports in every mode
  chk_p6_low_port: assert property (
    $past(rst_n_i) |-> port6_pins_oe_o[3:0] == ~$past(pm6_i[3:0]))
    else $error("lower port 6 pins taken");

  // Both strobes rest high between accesses
  chk_strobe_idle: assert property (
    (state_q == S_IDLE && exp_act) |=> port6_pins_o[P6_RD] && port6_pins_o[P6_WR])
    else $error("strobe active while idle");

  // External write drops the write strobe with the data on the low lines
  chk_wr_pulse: assert property (
    (state_q == S_STRB && ext_q && req_q.we) |=>
      !port6_pins_o[P6_WR] && port4_pins_o == req_q.wdata)
    else $error("write data phase wrong");

  // Address phase puts the low address byte on the shared lines
  chk_addr_phase: assert property (
    (state_q == S_ADDR && ext_q) |=> port4_pins_o == req_q.addr[7:0])
    else $error("low address phase wrong");

  // Address strobe pulses on every access in an expansion mode
  chk_address_latch_strobe_pulse: assert property (
    (state_q == S_ADDR && exp_act) |=> port6_pins_o[P6_ADDRESS_LATCH_STROBE])
    else $error("missing address strobe");

  // Main scenarios: external read, write, pin wait and internal access
  cov_ext_read: cover property (state_q == S_HOLD && ext_q && !req_q.we);
  cov_ext_write: cover property (state_q == S_HOLD && ext_q && req_q.we);
  cov_ext_wait: cover property (state_q == S_WAIT && wait_act_q == WAIT_EXT);
  cov_int_access: cover property (state_q == S_HOLD && !ext_q && exp_act);

endmodule // xmb_top

// File: core/xmb_pkg.sv
// Constants, types and decode helpers for the external memory expansion bus
// Function
// - Accesses outside internal areas go external
// - Bus works only on high-speed clock
// - Mode field codes; other codes never written
// - Reset clears mode register to single-chip
// - Port 4 data, port 5 upper address per mode
// - Port 6 upper pins: read, write, wait, strobe
// - Drive only mode-assigned upper address bits
// - Unassigned address pins stay general ports
// - Wait pin is port unless external wait
// - Low lines multiplexed, upper lines address only
// - Bit write is full 8-bit port access
// - Output mode write loads latch, drives pin
// - Reset clears every port output latch
// - Output mode read returns latch, unchanged
// - Input mode read returns pin level
// - Input mode write updates latch only
// - Input mode modify uses pin level operand
// - Output mode modify uses latch operand
// - Wait field resets one wait; one code forbidden
// - Read strobe only on external reads
// - Write strobe only on external writes
// - Internal access ignores wait, still strobes address
package xmb_pkg;

  // Register addresses in the CPU data space
  localparam logic [15:0] ADDR_PORT4 = 16'hff04;
  localparam logic [15:0] ADDR_PORT5 = 16'hff05;
  localparam logic [15:0] ADDR_PORT6 = 16'hff06;
  localparam logic [15:0] ADDR_MODE = 16'hff47;
  localparam logic [15:0] ADDR_WAIT = 16'hfff8;

  // Internal area bounds; external space lies strictly between them
  localparam logic [15:0] INT_ROM_LAST = 16'h5fff;
  localparam logic [15:0] INT_RAM_FIRST = 16'hfb00;

  // Reset values
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] WAIT_RESET = 8'h10;
  localparam logic [7:0] LATCH_RESET = 8'h00;

  // Field positions
  localparam int MODE_LSB = 0;
  localparam int WAIT_LSB = 4;

  // Expansion mode codes
  localparam logic [2:0] MODE_SINGLE = 3'h0;
  localparam logic [2:0] MODE_256B = 3'h3;
  localparam logic [2:0] MODE_4KB = 3'h4;
  localparam logic [2:0] MODE_16KB = 3'h5;
  localparam logic [2:0] MODE_FULL = 3'h7;

  // Wait control codes
  localparam logic [1:0] WAIT_NONE = 2'h0;
  localparam logic [1:0] WAIT_ONE = 2'h1;
  localparam logic [1:0] WAIT_BAD = 2'h2;
  localparam logic [1:0] WAIT_EXT = 2'h3;

  // Port 6 pin positions of the bus strobes
  localparam int P6_RD = 4;
  localparam int P6_WR = 5;
  localparam int P6_WAIT = 6;
  localparam int P6_ADDRESS_LATCH_STROBE = 7;

  // Bus cycle states
  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_ADDR = 5'b00010,
    S_STRB = 5'b00100,
    S_WAIT = 5'b01000,
    S_HOLD = 5'b10000
  } xmb_state_e;

  // One CPU access
  typedef struct packed {
    logic we;
    logic [15:0] addr;
    logic [7:0] wdata;
  } xmb_req_s;

  // Alternate-function override for one 8-bit port
  typedef struct packed {
    logic [7:0] sel;
    logic [7:0] val;
    logic [7:0] oe;
  } xmb_alt_s;

  // True for the four expansion codes
  function automatic logic mode_is_exp(input logic [2:0] m);
    return (m == MODE_256B) || (m == MODE_4KB) || (m == MODE_16KB) || (m == MODE_FULL);
  endfunction

  // Port 5 pins handed to the address bus in a mode
  function automatic logic [7:0] mode_addr_mask(input logic [2:0] m);
    unique case (m)
      MODE_4KB: return 8'h0f;
      MODE_16KB: return 8'h3f;
      MODE_FULL: return 8'hff;
      default: return 8'h00;
    endcase
  endfunction

  // True for an address in external expansion space
  function automatic logic addr_is_ext(input logic [15:0] a);
    return (a > INT_ROM_LAST) && (a < INT_RAM_FIRST);
  endfunction

endpackage

// File: core/xmb_port.sv
// One 8-bit port: output latch, read path and registered pin drive
`timescale 1ns/1ps
module xmb_port
  import xmb_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic wr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [7:0] pm_i,
  input wire logic [7:0] pin_i,
  input wire xmb_alt_s alt_i,
  output logic [7:0] rdata_o,
  output logic [7:0] pin_o,
  output logic [7:0] oe_o
);

  logic [7:0] latch_q; // Output latch
  logic [7:0] latch_d; // Latch next value

  // Whole byte written even for bit operations
  always_comb begin
    latch_d = wr_i ? wdata_i : latch_q;
  end

  // Output latch, cleared by reset
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      latch_q <= LATCH_RESET;
    end else begin
      latch_q <= latch_d;
    end
  end

  // Input bits read the pin, output bits read the latch
  always_comb begin
    rdata_o = (pm_i & pin_i) | (~pm_i & latch_q);
  end

  // Pin drive: bus function overrides, else latch with mode-controlled buffer
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_o <= 8'h00;
      oe_o <= 8'h00;
    end else begin
      pin_o <= (alt_i.sel & alt_i.val) | (~alt_i.sel & latch_d);
      oe_o <= (alt_i.sel & alt_i.oe) | (~alt_i.sel & ~pm_i);
    end
  end

  // Latch only moves on a write
  chk_latch_hold: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i) !wr_i |=> $stable(latch_q))
    else $error("latch changed without write");
  // Input-mode port pin keeps its buffer off
  chk_input_off: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i) (pm_i[0] && !alt_i.sel[0]) |=> !oe_o[0])
    else $error("input pin driven");

endmodule // xmb_port

// File: verif/xmb_ext_mem.sv
// External memory model on the far side of the expansion bus
`timescale 1ns/1ps
module xmb_ext_mem (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] bus4_i,
  input wire logic [7:0] bus5_i,
  input wire logic [7:0] bus6_i,
  input wire logic [7:0] bus6_oe_i,
  input wire logic [3:0] wait_len_i,
  output logic [7:0] ad_drv_o,
  output logic ad_en_o,
  output logic wait_n_o,
  output logic [15:0] adr_o,
  output logic [7:0] rd_cnt_o,
  output logic [7:0] wr_cnt_o
);
  logic [7:0] mem_q [0:255]; // Storage indexed by low address byte
  logic rd_act; // Read strobe asserted
  logic wr_act; // Write strobe asserted
  logic address_latch_strobe; // Address strobe asserted
  logic rd_prev_q; // Strobe history for pulse counts
  logic wr_prev_q;
  logic [3:0] wcnt_q; // Remaining wait cycles

  assign rd_act = bus6_oe_i[4] & ~bus6_i[4];
  assign wr_act = bus6_oe_i[5] & ~bus6_i[5];
  assign address_latch_strobe = bus6_oe_i[7] & bus6_i[7];
  // Data is driven onto the low lines only while reading
  assign ad_en_o = rd_act;
  assign ad_drv_o = mem_q[adr_o[7:0]];
  // Wait pin drops with the address strobe so the controller sees it in its
  // strobe cycle, then stays low for the commanded count
  assign wait_n_o = !((address_latch_strobe && wait_len_i != 4'h0) || wcnt_q != 4'h0);

  // Address latch, strobe counters and wait counter
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      adr_o <= 16'h0000;
      rd_cnt_o <= 8'h00;
      wr_cnt_o <= 8'h00;
      rd_prev_q <= 1'b0;
      wr_prev_q <= 1'b0;
      wcnt_q <= 4'h0;
    end else begin
      if (address_latch_strobe) begin
        adr_o <= {bus5_i, bus4_i};
      end
      rd_prev_q <= rd_act;
      wr_prev_q <= wr_act;
      if (rd_act && !rd_prev_q) begin
        rd_cnt_o <= rd_cnt_o + 8'h01;
      end
      if (wr_act && !wr_prev_q) begin
        wr_cnt_o <= wr_cnt_o + 8'h01;
      end
      wcnt_q <= address_latch_strobe ? wait_len_i : (wcnt_q != 4'h0 ? wcnt_q - 4'h1 : 4'h0);
    end
  end

  // Write data is taken from the low lines while the write strobe is low
  always_ff @(posedge mclk_i) begin
    if (wr_act) begin
      mem_q[adr_o[7:0]] <= bus4_i;
    end
  end
endmodule // xmb_ext_mem

// File: verif/tb.sv
// Self-checking testbench for the expansion bus controller
`timescale 1ns/1ps
module tb;
  import xmb_pkg::*;
  logic clk, rst_n, hs, req, we, ack, ad_en, wait_n;
  logic [15:0] addr, adr;
  logic [7:0] wd, rdata, pm4, pm5, pm6, ext4, ext5, ext6, ad_drv, rc, wc;
  logic [7:0] p4o, p4oe, p5o, p5oe, p6o, p6oe, p4i, p5i, p6i, r, m8;
  logic [3:0] wlen;
  logic [15:0] ea [4];
  logic [2:0] em [4];
  int error_cnt, num_checks, lat, i;

  // Pin levels resolved from every party's enables
  assign p4i = (p4oe & p4o) | (~p4oe & (ad_en ? ad_drv : ext4));
  assign p5i = (p5oe & p5o) | (~p5oe & ext5);
  assign p6i = (p6oe & p6o) | (~p6oe & {ext6[7], wait_n, ext6[5:0]});

  xmb_top dut_u (.mclk_i(clk), .rst_n_i(rst_n), .hs_clk_sel_i(hs), .cpu_req_i(req),
    .cpu_we_i(we), .cpu_addr_i(addr), .cpu_wdata_i(wd), .cpu_ack_o(ack),
    .cpu_rdata_o(rdata), .pm4_i(pm4), .pm5_i(pm5), .pm6_i(pm6),
    .port4_pins_i(p4i), .port4_pins_o(p4o), .port4_pins_oe_o(p4oe),
    .port5_pins_i(p5i), .port5_pins_o(p5o), .port5_pins_oe_o(p5oe),
    .port6_pins_i(p6i), .port6_pins_o(p6o), .port6_pins_oe_o(p6oe));

  xmb_ext_mem mem_u (.mclk_i(clk), .rst_n_i(rst_n), .bus4_i(p4o), .bus5_i(p5o),
    .bus6_i(p6o), .bus6_oe_i(p6oe), .wait_len_i(wlen), .ad_drv_o(ad_drv),
    .ad_en_o(ad_en), .wait_n_o(wait_n), .adr_o(adr), .rd_cnt_o(rc), .wr_cnt_o(wc));

  // Free-running 125 MHz clock
  always #4 clk = ~clk;

  // Compare and count
  task chk(input logic [15:0] s, input logic [15:0] e);
    num_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  // Verdict and end of run
  task end_of_test;
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // One CPU access; returns data and the cycle of acknowledge, take cycle being 1
  task acc(input logic w, input logic [15:0] a, input logic [7:0] d);
    req = 1'b1;
    we = w;
    addr = a;
    wd = d;
    lat = 1;
    @(posedge clk);
    #1 req = 1'b0;
    do begin
      @(posedge clk);
      #1 lat++;
    end while (ack !== 1'b1 && lat < 40);
    // A missing acknowledge counts as a mismatch
    if (ack !== 1'b1) begin
      error_cnt++;
    end
    r = rdata;
  endtask

  // Read and compare
  task rdchk(input logic [15:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    chk(r, e);
  endtask

  // Let n clock edges pass
  task idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Port 5 pins owned by the address bus in each mode
  function automatic logic [7:0] amask(input logic [2:0] m);
    case (m)
      3'h4: return 8'h0f;
      3'h5: return 8'h3f;
      3'h7: return 8'hff;
      default: return 8'h00;
    endcase
  endfunction

  initial begin
    clk = 0; rst_n = 0; hs = 1; req = 0; we = 0; addr = 0; wd = 0; wlen = 0;
    pm4 = 8'h00; pm5 = 8'hff; pm6 = 8'hff; ext4 = 8'h00; ext5 = 8'h5a; ext6 = 8'hff;
    error_cnt = 0; num_checks = 0;
    em = '{3'h3, 3'h4, 3'h5, 3'h7};
    ea = '{16'h6155, 16'h6a33, 16'h9fe7, 16'hf7ff};
    repeat (4) @(posedge clk);
    #1 rst_n = 1;
    idle(1);
    // Reset state of registers and ports
    chk(p4oe, 8'hff);
    rdchk(ADDR_MODE, 8'h00);
    rdchk(ADDR_WAIT, 8'h10);
    rdchk(ADDR_PORT4, 8'h00);
    rdchk(ADDR_PORT5, 8'h5a);
    // Mixed-direction port: latch, pin and read paths
    pm4 = 8'h0f;
    ext4 = 8'h3c;
    acc(1'b1, ADDR_PORT4, 8'ha5);
    idle(1);
    chk(p4o & 8'hf0, 8'ha0);
    chk(p4oe, 8'hf0);
    rdchk(ADDR_PORT4, 8'hac);
    acc(1'b1, ADDR_PORT4, r | 8'h01);
    pm4 = 8'h00;
    idle(1);
    chk(p4o, 8'had);
    rdchk(ADDR_PORT4, 8'had);
    acc(1'b1, ADDR_WAIT, 8'h00);
    // Each expansion mode: pin ownership, external write and read
    for (i = 0; i < 4; i++) begin
      m8 = {5'h00, em[i]};
      acc(1'b1, ADDR_MODE, m8);
      rdchk(ADDR_MODE, m8);
      idle(2);
      chk(p5oe, amask(em[i]));
      chk(p6oe, 8'hb0);
      acc(1'b1, ea[i], ea[i][7:0] ^ 8'h96);
      chk(16'(lat), 16'h0004);
      chk(adr & {amask(em[i]), 8'hff}, ea[i] & {amask(em[i]), 8'hff});
      chk(p5o & ~amask(em[i]), 8'h00);
      chk(p4oe, 8'hff);
      acc(1'b0, ea[i], 8'h00);
      chk(r, ea[i][7:0] ^ 8'h96);
      chk(16'(lat), 16'h0004);
      chk({wc, rc}, {i[7:0] + 8'h01, i[7:0] + 8'h01});
      acc(1'b1, ADDR_PORT6, 8'h00);
      rdchk(ADDR_MODE, m8);
      chk({wc, rc}, {i[7:0] + 8'h01, i[7:0] + 8'h01});
    end
    // Prohibited mode codes leave the full-address mode in place
    acc(1'b1, ADDR_MODE, 8'h01);
    acc(1'b1, ADDR_MODE, 8'h02);
    acc(1'b1, ADDR_MODE, 8'h06);
    rdchk(ADDR_MODE, 8'h07);
    // One inserted wait, prohibited code, then external wait pin
    acc(1'b1, ADDR_WAIT, 8'h10);
    rdchk(16'h6155, 8'h55 ^ 8'h96);
    chk(16'(lat), 16'h0005);
    acc(1'b1, ADDR_WAIT, 8'h20);
    rdchk(ADDR_WAIT, 8'h10);
    acc(1'b1, ADDR_WAIT, 8'h30);
    wlen = 4'h3;
    rdchk(16'h6a33, 8'h33 ^ 8'h96);
    chk(16'(lat), 16'h0008);
    chk(p6oe[6], 1'b0);
    rdchk(ADDR_MODE, 8'h07);
    chk(16'(lat), 16'h0003);
    wlen = 4'h0;
    // Bus unavailable off the high-speed clock
    hs = 1'b0;
    rdchk(16'h9fe7, 8'h00);
    chk(16'(lat), 16'h0003);
    chk(rc, 8'h06);
    hs = 1'b1;
    // Back to single-chip: every pin a port again
    acc(1'b1, ADDR_MODE, 8'h00);
    idle(2);
    chk(p6oe, 8'h00);
    rdchk(16'hf7ff, 8'h00);
    chk(16'(lat), 16'h0003);
    end_of_test;
  end

  // Watchdog against a hung handshake
  initial begin
    #50000;
    error_cnt++;
    end_of_test;
  end
endmodule // tb
